// ### afo_defs.svh
// Offsets, pattern codes, fixed words and timing counts of the output formatter
`ifndef AFO_DEFS_SVH
`define AFO_DEFS_SVH
`define AFO_OFS_TEST_SEL   8'h0d
`define AFO_OFS_USER1_LO   8'h19
`define AFO_OFS_USER1_HI   8'h1a
`define AFO_OFS_USER2_LO   8'h1b
`define AFO_OFS_USER2_HI   8'h1c
`define AFO_TEST_SEL_RST   8'h00
`define AFO_USER_RST       8'h00
`define AFO_PN_RST_A_BIT   4
`define AFO_PN_RST_B_BIT   5
`define AFO_M_OFF          4'h0
`define AFO_M_MIDSCALE     4'h1
`define AFO_M_POS_FS       4'h2
`define AFO_M_NEG_FS       4'h3
`define AFO_M_CHECKER      4'h4
`define AFO_M_PN_LONG      4'h5
`define AFO_M_PN_SHORT     4'h6
`define AFO_M_WORD_TOG     4'h7
`define AFO_M_USER         4'h8
`define AFO_M_BIT_TOG      4'h9
`define AFO_M_SYNC         4'ha
`define AFO_M_ONE_HIGH     4'hb
`define AFO_M_MIXED        4'hc
`define AFO_W_MID          14'h2000
`define AFO_W_ONES         14'h3fff
`define AFO_W_ZEROS        14'h0000
`define AFO_W_CHK          14'h2aaa
`define AFO_W_SYNC14       14'h007f
`define AFO_W_SYNC12       14'h00fc
`define AFO_W_MIX14        14'h2867
`define AFO_W_MIX12        14'h28cc
`define AFO_PN9_SEED       9'h1ff
`define AFO_PN9_TAP        4
`define AFO_LONG_PRBS_SEED      23'h7fffff
`define AFO_LONG_PRBS_TAP       17
`define AFO_LAST_BIT14     4'd13
`define AFO_LAST_BIT12     4'd11
`define AFO_CLK_PS         5000
`define AFO_BIT_PS         30000
`define AFO_BIT_CYC        (`AFO_BIT_PS / `AFO_CLK_PS)
`define AFO_DEF_PHASE      3'd3
`define AFO_STRAP_SETTLE   2'd3
`endif

// ### afo_pkg.sv
// Types shared by the output formatter
package afo_pkg;
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} afo_cfg_req_t;
	typedef enum logic [0:0] {AFO_ST_SETTLE, AFO_ST_DONE} afo_strap_st_t;
endpackage

// ### afo_formatter.sv
// Serial output formatter with test pattern generation for a two-bank converter
// Behaviour
// - Data clock phase steps of 60 degrees
// - Default data clock edge mid-bit
// - 12-bit mode shortens each word except the pseudorandom ones
// - MSB first, LSB first when selected
// - Four-bit test code, zero means normal
// - Midscale and full-scale words follow format
// - Checkerboard alternates with complement, unconverted
// - Word toggle and bit toggle, unconverted
// - Two alternating user words from registers
// - Sync word per word length
// - One-bit-high and mixed-frequency words
// - Pseudorandom patterns always 14 bits
// - Short sequence x^9+x^5+1, all-ones seed
// - Short sequence packed oldest bit first
// - Long sequence x^23+x^18+1, all-ones seed
// - Long sequence uninverted, packed oldest first
// - Format strap selects two's complement
// - Pattern strap at power-up forces word
// - Clocks keep running under strap pattern
// - Deselected bank ignores register writes
// - Reset bits reseed pseudorandom generators
// - Test patterns replace converter samples
// - Frame clock per word, DDR data clock
`timescale 1ns/10ps
`include "afo_defs.svh"
module afo_formatter #(
	parameter int LANES      = 16,
	parameter int BANK_LANES = 8
) (
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// Converter samples, offset binary, 14 bits per lane
	input  wire logic [LANES*14-1:0]   samples_i,
	// Register access from the serial port decoder
	input  wire afo_pkg::afo_cfg_req_t cfg_req_i,
	output logic      [7:0]            cfg_rdata_o,
	// Output timing and format controls
	input  wire logic [2:0]            clk_phase_i,
	input  wire logic                  word_12bit_i,
	input  wire logic                  lsb_first_i,
	input  wire logic                  format_twos_i,
	// Control pins
	input  wire logic                  bank_one_select_n_i,
	input  wire logic                  bank_two_select_n_i,
	input  wire logic                  serial_clock_or_pattern_pin_i,
	input  wire logic                  serial_io_or_format_pin_i,
	output logic                       serial_io_or_format_pin_o,
	output logic                       serial_io_or_format_pin_oe_o,
	// Serial link
	output logic      [LANES-1:0]      lane_outputs_o,
	output logic      [1:0]            word_frame_clock_o,
	output logic      [1:0]            bit_capture_clock_o
);
	import afo_pkg::*;

	localparam int         BIT_CYC = `AFO_BIT_CYC;
	localparam logic [2:0] PH_LAST = 3'(BIT_CYC - 1);

	// Pin synchronisers: [0] bank one, [1] bank two, [2] pattern, [3] format
	logic [3:0]    sync1_r;
	logic [3:0]    sync1_nxt;
	logic [3:0]    sync2_r;
	logic [3:0]    sync2_nxt;
	logic [1:0]    bank_sel_n;
	logic          spi_off;
	afo_strap_st_t strap_st_r;
	afo_strap_st_t strap_st_nxt;
	logic [1:0]    settle_r;
	logic [1:0]    settle_nxt;
	logic          strap_on_r;
	logic          strap_on_nxt;

	// Register file, one copy per bank
	logic [7:0]    test_sel_r  [2];
	logic [7:0]    test_sel_nxt[2];
	logic [7:0]    user_r      [2][4];
	logic [7:0]    user_nxt    [2][4];
	logic [7:0]    rdata_r;
	logic [7:0]    rdata_nxt;
	logic          rd_bank;

	// Timing and serialiser state
	logic [2:0]    ph_r;
	logic [2:0]    ph_nxt;
	logic          dco_r;
	logic          dco_nxt;
	logic [1:0]    fco_r;
	logic [1:0]    fco_nxt;
	logic [3:0]    bit_r    [2];
	logic [3:0]    bit_nxt  [2];
	logic [3:0]    last_r   [2];
	logic [3:0]    last_nxt [2];
	logic [1:0]    alt_r;
	logic [1:0]    alt_nxt;
	logic [8:0]    pn9_r    [2];
	logic [8:0]    pn9_nxt  [2];
	logic [22:0]   long_prbs_r   [2];
	logic [22:0]   long_prbs_nxt [2];
	logic [13:0]   shift_r  [LANES];
	logic [13:0]   shift_nxt[LANES];
	logic [LANES-1:0] lane_r;
	logic [LANES-1:0] lane_nxt;

	// Combinational temporaries
	logic [2:0]    phase;
	logic          twos;
	logic          bit_end;
	logic [3:0]    mode;
	logic [22:0]   pn9_s;
	logic [36:0]   long_prbs_s;
	logic [15:0]   user_w;
	logic [13:0]   pat_b [2];
	logic [1:0]    conv_b;
	logic [1:0]    norm_b;
	logic [1:0]    w12_b;
	logic [1:0]    wend_b;
	logic          two_word;
	logic [13:0]   w;
	logic          bk;

	function automatic logic [22:0] pn9_adv(input logic [8:0] s);
		logic [8:0]  st;
		logic [13:0] wd;
		st = s;
		wd = 14'h0000;
		for (int i = 0; i < 14; i++) begin
			wd = {wd[12:0], st[8]};
			st = {st[7:0], st[8] ^ st[`AFO_PN9_TAP]};
		end
		return {wd, st};
	endfunction

	function automatic logic [36:0] long_prbs_adv(input logic [22:0] s);
		logic [22:0] st;
		logic [13:0] wd;
		st = s;
		wd = 14'h0000;
		for (int i = 0; i < 14; i++) begin
			wd = {wd[12:0], st[22]};
			st = {st[21:0], st[22] ^ st[`AFO_LONG_PRBS_TAP]};
		end
		return {wd, st};
	endfunction

	function automatic logic [13:0] rev14(input logic [13:0] v);
		logic [13:0] r;
		r = 14'h0000;
		for (int i = 0; i < 14; i++) begin
			r[i] = v[13-i];
		end
		return r;
	endfunction

	assign bank_sel_n = sync2_r[1:0];
	assign spi_off    = &bank_sel_n;

	always_comb begin
		sync1_nxt = {serial_io_or_format_pin_i, serial_clock_or_pattern_pin_i,
			bank_two_select_n_i, bank_one_select_n_i};
		sync2_nxt = sync1_r;
		strap_st_nxt = strap_st_r;
		settle_nxt   = settle_r;
		strap_on_nxt = strap_on_r;
		case (strap_st_r)
			AFO_ST_SETTLE: begin
				// Wait until the synchronisers hold pin levels, then catch once
				if (settle_r == `AFO_STRAP_SETTLE) begin
					strap_on_nxt = sync2_r[2] & spi_off;
					strap_st_nxt = AFO_ST_DONE;
				end else begin
					settle_nxt = settle_r + 2'd1;
				end
			end
			AFO_ST_DONE: begin
				strap_st_nxt = AFO_ST_DONE;
			end
			default: begin
				strap_st_nxt = AFO_ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_r    <= 4'h0;
			sync2_r    <= 4'h0;
			strap_st_r <= AFO_ST_SETTLE;
			settle_r   <= 2'd0;
			strap_on_r <= 1'b0;
		end else begin
			sync1_r    <= sync1_nxt;
			sync2_r    <= sync2_nxt;
			strap_st_r <= strap_st_nxt;
			settle_r   <= settle_nxt;
			strap_on_r <= strap_on_nxt;
		end
	end

	always_comb begin
		test_sel_nxt = test_sel_r;
		user_nxt     = user_r;
		for (int b = 0; b < 2; b++) begin
			if (cfg_req_i.wr && !bank_sel_n[b]) begin
				case (cfg_req_i.addr)
					`AFO_OFS_TEST_SEL: test_sel_nxt[b] = cfg_req_i.data;
					`AFO_OFS_USER1_LO: user_nxt[b][0] = cfg_req_i.data;
					`AFO_OFS_USER1_HI: user_nxt[b][1] = cfg_req_i.data;
					`AFO_OFS_USER2_LO: user_nxt[b][2] = cfg_req_i.data;
					`AFO_OFS_USER2_HI: user_nxt[b][3] = cfg_req_i.data;
					default: begin
					end
				endcase
			end
		end
		// Bank one answers unless only bank two is selected
		rd_bank = bank_sel_n[0] & ~bank_sel_n[1];
		case (cfg_req_i.addr)
			`AFO_OFS_TEST_SEL: rdata_nxt = test_sel_r[rd_bank];
			`AFO_OFS_USER1_LO: rdata_nxt = user_r[rd_bank][0];
			`AFO_OFS_USER1_HI: rdata_nxt = user_r[rd_bank][1];
			`AFO_OFS_USER2_LO: rdata_nxt = user_r[rd_bank][2];
			`AFO_OFS_USER2_HI: rdata_nxt = user_r[rd_bank][3];
			default:           rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int b = 0; b < 2; b++) begin
				test_sel_r[b] <= `AFO_TEST_SEL_RST;
				for (int k = 0; k < 4; k++) begin
					user_r[b][k] <= `AFO_USER_RST;
				end
			end
			rdata_r <= 8'h00;
		end else begin
			test_sel_r <= test_sel_nxt;
			user_r     <= user_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	always_comb begin
		phase   = (clk_phase_i > PH_LAST) ? PH_LAST : clk_phase_i;
		twos    = spi_off ? sync2_r[3] : format_twos_i;
		bit_end = (ph_r == PH_LAST);
		ph_nxt  = bit_end ? 3'd0 : ph_r + 3'd1;
		// Even toggle count per word keeps the data clock locked to the frame
		// Toggle lands on the cycle where the bit phase equals the step, so step 3 is mid-bit
		dco_nxt = (ph_nxt == phase) ? ~dco_r : dco_r;
		fco_nxt   = fco_r;
		bit_nxt   = bit_r;
		last_nxt  = last_r;
		alt_nxt   = alt_r;
		pn9_nxt   = pn9_r;
		long_prbs_nxt  = long_prbs_r;
		shift_nxt = shift_r;
		lane_nxt  = lane_r;
		mode      = `AFO_M_OFF;
		pn9_s     = 23'h000000;
		long_prbs_s    = 37'h0;
		user_w    = 16'h0000;
		two_word  = 1'b0;
		w         = 14'h0000;
		bk        = 1'b0;
		for (int b = 0; b < 2; b++) begin
			mode      = strap_on_r ? `AFO_M_ONE_HIGH : test_sel_r[b][3:0];
			pn9_s     = pn9_adv(pn9_r[b]);
			long_prbs_s    = long_prbs_adv(long_prbs_r[b]);
			user_w    = alt_r[b] ? {user_r[b][3], user_r[b][2]} : {user_r[b][1], user_r[b][0]};
			w12_b[b]  = word_12bit_i && mode != `AFO_M_PN_LONG && mode != `AFO_M_PN_SHORT;
			wend_b[b] = bit_end && (bit_r[b] == last_r[b]);
			conv_b[b] = 1'b0;
			norm_b[b] = 1'b0;
			two_word  = 1'b0;
			case (mode)
				`AFO_M_MIDSCALE: begin pat_b[b] = `AFO_W_MID; conv_b[b] = 1'b1; end
				`AFO_M_POS_FS:   begin pat_b[b] = `AFO_W_ONES; conv_b[b] = 1'b1; end
				`AFO_M_NEG_FS:   begin pat_b[b] = `AFO_W_ZEROS; conv_b[b] = 1'b1; end
				`AFO_M_CHECKER:  begin
					pat_b[b] = alt_r[b] ? ~`AFO_W_CHK : `AFO_W_CHK;
					two_word = 1'b1;
				end
				`AFO_M_PN_LONG:  begin pat_b[b] = long_prbs_s[36:23]; conv_b[b] = 1'b1; end
				`AFO_M_PN_SHORT: begin pat_b[b] = pn9_s[22:9]; conv_b[b] = 1'b1; end
				`AFO_M_WORD_TOG: begin
					pat_b[b] = alt_r[b] ? `AFO_W_ZEROS : `AFO_W_ONES;
					two_word = 1'b1;
				end
				`AFO_M_USER:     begin pat_b[b] = user_w[15:2]; two_word = 1'b1; end
				`AFO_M_BIT_TOG:  pat_b[b] = `AFO_W_CHK;
				`AFO_M_SYNC:     pat_b[b] = w12_b[b] ? `AFO_W_SYNC12 : `AFO_W_SYNC14;
				`AFO_M_ONE_HIGH: pat_b[b] = `AFO_W_MID;
				`AFO_M_MIXED:    pat_b[b] = w12_b[b] ? `AFO_W_MIX12 : `AFO_W_MIX14;
				default: begin
					pat_b[b]  = `AFO_W_ZEROS;
					norm_b[b] = 1'b1;
					conv_b[b] = 1'b1;
				end
			endcase
			// Reseed while idle so each selection starts from the first word
			if (mode != `AFO_M_PN_SHORT || test_sel_r[b][`AFO_PN_RST_A_BIT] || test_sel_r[b][`AFO_PN_RST_B_BIT]) begin
				pn9_nxt[b] = `AFO_PN9_SEED;
			end else if (wend_b[b]) begin
				pn9_nxt[b] = pn9_s[8:0];
			end
			if (mode != `AFO_M_PN_LONG || test_sel_r[b][`AFO_PN_RST_A_BIT] || test_sel_r[b][`AFO_PN_RST_B_BIT]) begin
				long_prbs_nxt[b] = `AFO_LONG_PRBS_SEED;
			end else if (wend_b[b]) begin
				long_prbs_nxt[b] = long_prbs_s[22:0];
			end
			if (!two_word) begin
				alt_nxt[b] = 1'b0;
			end else if (wend_b[b]) begin
				alt_nxt[b] = ~alt_r[b];
			end
			if (wend_b[b]) begin
				bit_nxt[b]  = 4'd0;
				last_nxt[b] = w12_b[b] ? `AFO_LAST_BIT12 : `AFO_LAST_BIT14;
				fco_nxt[b]  = 1'b1;
			end else if (bit_end) begin
				bit_nxt[b] = bit_r[b] + 4'd1;
				if (bit_r[b] == (last_r[b] >> 1)) begin
					fco_nxt[b] = 1'b0;
				end
			end
		end
		for (int l = 0; l < LANES; l++) begin
			bk = (l >= BANK_LANES);
			w  = norm_b[bk] ? samples_i[l*14 +: 14] : pat_b[bk];
			if (conv_b[bk] && twos) begin
				w[13] = ~w[13];
			end
			if (lsb_first_i) begin
				w = rev14(w) << (w12_b[bk] ? 2 : 0);
			end
			if (wend_b[bk]) begin
				shift_nxt[l] = {w[12:0], 1'b0};
				lane_nxt[l]  = w[13];
			end else if (bit_end) begin
				shift_nxt[l] = {shift_r[l][12:0], 1'b0};
				lane_nxt[l]  = shift_r[l][13];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ph_r   <= 3'd0;
			dco_r  <= 1'b0;
			fco_r  <= 2'b00;
			alt_r  <= 2'b00;
			lane_r <= '0;
			for (int b = 0; b < 2; b++) begin
				bit_r[b]  <= 4'd0;
				last_r[b] <= `AFO_LAST_BIT14;
				pn9_r[b]  <= `AFO_PN9_SEED;
				long_prbs_r[b] <= `AFO_LONG_PRBS_SEED;
			end
			for (int l = 0; l < LANES; l++) begin
				shift_r[l] <= 14'h0000;
			end
		end else begin
			ph_r    <= ph_nxt;
			dco_r   <= dco_nxt;
			fco_r   <= fco_nxt;
			alt_r   <= alt_nxt;
			lane_r  <= lane_nxt;
			bit_r   <= bit_nxt;
			last_r  <= last_nxt;
			pn9_r   <= pn9_nxt;
			long_prbs_r  <= long_prbs_nxt;
			shift_r <= shift_nxt;
		end
	end

	// Readback drive belongs to the serial port, which is not built here
	assign serial_io_or_format_pin_o    = 1'b0;
	assign serial_io_or_format_pin_oe_o = 1'b0;
	assign cfg_rdata_o         = rdata_r;
	assign lane_outputs_o      = lane_r;
	assign word_frame_clock_o  = fco_r;
	assign bit_capture_clock_o = {dco_r, dco_r};
endmodule

// ### afo_formatter_checker.sv
// Port-level assertions for the output formatter
`timescale 1ns/10ps
`include "afo_defs.svh"
module afo_formatter_checker #(
	parameter int LANES = 16
) (
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// Register port and controls
	input  wire afo_pkg::afo_cfg_req_t cfg_req_i,
	input  wire logic [7:0]            cfg_rdata_o,
	input  wire logic [2:0]            clk_phase_i,
	input  wire logic                  bank_one_select_n_i,
	input  wire logic                  bank_two_select_n_i,
	input  wire logic                  serial_io_or_format_pin_oe_o,
	// Serial link
	input  wire logic [LANES-1:0]      lane_outputs_o,
	input  wire logic [1:0]            word_frame_clock_o,
	input  wire logic [1:0]            bit_capture_clock_o
);
	import afo_pkg::*;
	logic [2:0] ph_r;
	logic [3:0] hold_r, hold_nxt, sel_r, sel_nxt, des_r, des_nxt;
	logic       mapped, user;
	assign user   = cfg_req_i.addr inside {[`AFO_OFS_USER1_LO:`AFO_OFS_USER2_HI]};
	assign mapped = user || cfg_req_i.addr == `AFO_OFS_TEST_SEL;
	// Saturating counts; selects pass a synchroniser, so only long-settled levels are trusted
	always_comb begin
		hold_nxt = (clk_phase_i != ph_r) ? 4'h0 : hold_r + {3'h0, hold_r != 4'hf};
		sel_nxt  = (bank_one_select_n_i | bank_two_select_n_i) ? 4'h0 : sel_r + {3'h0, sel_r != 4'hf};
		des_nxt  = (bank_one_select_n_i & bank_two_select_n_i) ? des_r + {3'h0, des_r != 4'hf} : 4'h0;
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ph_r   <= 3'h0;
			hold_r <= 4'h0;
			sel_r  <= 4'h0;
			des_r  <= 4'h0;
		end else begin
			ph_r   <= clk_phase_i;
			hold_r <= hold_nxt;
			sel_r  <= sel_nxt;
			des_r  <= des_nxt;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_frame_high: assert property (
		$rose(word_frame_clock_o[0]) |-> word_frame_clock_o[0] [*8] ##[29:35] $fell(word_frame_clock_o[0]))
		else $error("frame clock high time wrong");
	a_frame_period: assert property (
		$rose(word_frame_clock_o[0]) |-> ##[72:84] $rose(word_frame_clock_o[0]))
		else $error("frame clock period wrong");
	a_dclk_half: assert property (
		$changed(bit_capture_clock_o[0]) && hold_r > 4'd11 |-> ##6 ($changed(bit_capture_clock_o[0]) || hold_nxt < 4'd7))
		else $error("data clock half period wrong");
	a_lane_hold: assert property (
		$changed(lane_outputs_o[0]) |=> $stable(lane_outputs_o[0]) [*5])
		else $error("lane bit shorter than six cycles");
	a_unmapped_zero: assert property (
		!mapped |=> cfg_rdata_o == 8'h00)
		else $error("unmapped address read not zero");
	a_user_readback: assert property (
		cfg_req_i.wr && user && sel_r > 4'd3 ##1 !cfg_req_i.wr && $stable(cfg_req_i.addr)
		|=> cfg_rdata_o == $past(cfg_req_i.data, 2))
		else $error("user register readback wrong");
	a_desel_drop: assert property (
		cfg_req_i.wr && mapped && des_r > 4'd3 ##1 !cfg_req_i.wr && $stable(cfg_req_i.addr) |=> $stable(cfg_rdata_o))
		else $error("write taken by deselected bank");
	a_oe_low: assert property (
		!serial_io_or_format_pin_oe_o)
		else $error("format pin driven");
	c_frame: cover property ($rose(word_frame_clock_o[0]));
	c_user_wr: cover property (cfg_req_i.wr && user && sel_r > 4'd3);
	c_desel_wr: cover property (cfg_req_i.wr && des_r > 4'd3);
endmodule
bind afo_formatter afo_formatter_checker #(.LANES(LANES)) i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .clk_phase_i(clk_phase_i),
	.bank_one_select_n_i(bank_one_select_n_i), .bank_two_select_n_i(bank_two_select_n_i),
	.serial_io_or_format_pin_oe_o(serial_io_or_format_pin_oe_o), .lane_outputs_o(lane_outputs_o),
	.word_frame_clock_o(word_frame_clock_o), .bit_capture_clock_o(bit_capture_clock_o));

// ### afo_rx.sv
// Receiver model: deserialises one lane on both data clock edges
`timescale 1ns/10ps
module afo_rx (
	// Link
	input  wire logic        mclk_i,
	input  wire logic        lane_i,
	input  wire logic        frame_i,
	input  wire logic        dclk_i,
	// Captured word
	output logic      [13:0] word_o,
	output logic             got_o
);
	logic [13:0] sh_r;
	logic        frame_r, dclk_r;
	// Frame rise publishes the last 14 bits shifted in, so a 12-bit word sits in the low bits
	always @(posedge mclk_i) begin
		frame_r <= frame_i;
		dclk_r  <= dclk_i;
		got_o   <= frame_i && !frame_r;
		if (frame_i && !frame_r)
			word_o <= sh_r;
		if (dclk_i != dclk_r)
			sh_r <= {sh_r[12:0], lane_i};
	end
endmodule

// ### afo_formatter_tb.sv
// Self-checking bench for the output formatter
`timescale 1ns/10ps
`include "afo_defs.svh"
module afo_formatter_tb;
	import afo_pkg::*;
	logic mclk_i = 0, rst_n_i = 0, w12 = 0, lsb = 0, twos = 0, sel1_n = 0, sel2_n = 0, pat = 0, fmt = 0;
	logic [2:0] ph = 3'd3;
	afo_cfg_req_t req = '0;
	logic [7:0] rdata;
	logic [15:0] lanes;
	logic [1:0] frame, dclk, got;
	logic [1:0][13:0] wd;
	logic sdo;
	logic [13:0] w;
	int bad_count = 0, check_count = 0, m0, m;
	logic [7:0] ra [6] = '{8'h0d, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h20};
	logic [7:0] ud [4] = '{8'hcd, 8'hab, 8'h34, 8'h12};
	logic [3:0] cd [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
	logic [13:0] w1 [11] = '{14'h1234, 14'h2000, 14'h3fff, 14'h0000, 14'h2aaa, 14'h3fff,
		14'h2af3, 14'h2aaa, 14'h007f, 14'h2000, 14'h2867};
	logic [13:0] w2 [11] = '{14'h1234, 14'h2000, 14'h3fff, 14'h0000, 14'h1555, 14'h0000,
		14'h048d, 14'h2aaa, 14'h007f, 14'h2000, 14'h2867};
	logic [7:0] c12 [4] = '{8'h1, 8'ha, 8'hc, 8'h6};
	logic [13:0] e12 [4] = '{14'h800, 14'h3f, 14'ha33, 14'h3fe0};
	logic [13:0] p9 [4] = '{14'h1fe0, 14'h1df1, 14'h3cc8, 14'h294e};
	logic [13:0] p23 [4] = '{14'h1fff, 14'h1fe0, 14'h2001, 14'h1c00};
	always #2.5 mclk_i = ~mclk_i;
	afo_formatter i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .samples_i({16{14'h1234}}), .cfg_req_i(req),
		.cfg_rdata_o(rdata), .clk_phase_i(ph), .word_12bit_i(w12), .lsb_first_i(lsb), .format_twos_i(twos),
		.bank_one_select_n_i(sel1_n), .bank_two_select_n_i(sel2_n), .serial_clock_or_pattern_pin_i(pat),
		.serial_io_or_format_pin_i(fmt), .serial_io_or_format_pin_o(sdo), .serial_io_or_format_pin_oe_o(),
		.lane_outputs_o(lanes), .word_frame_clock_o(frame), .bit_capture_clock_o(dclk));
	for (genvar b = 0; b < 2; b++) begin : g_rx
		afo_rx i_rx (.mclk_i(mclk_i), .lane_i(lanes[b*8]), .frame_i(frame[b]), .dclk_i(dclk[b]),
			.word_o(wd[b]), .got_o(got[b]));
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [13:0] seen, exp, input string nm);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge mclk_i);
		req = '{1'b1, a, d};
		@(negedge mclk_i);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(negedge mclk_i);
		req.addr = a;
		@(negedge mclk_i);
		chk({6'h0, rdata}, {6'h0, e}, "rdata");
	endtask
	task automatic getw(input int b, output logic [13:0] v);
		int n;
		n = 0;
		while (got[b] !== 1'b1 && n < 400) begin
			@(negedge mclk_i);
			n++;
		end
		if (n == 400) begin
			bad_count++;
			tally_and_finish();
		end
		v = wd[b];
		@(negedge mclk_i);
	endtask
	task automatic expw(input int b, input logic [13:0] e);
		logic [13:0] v;
		getw(b, v);
		chk(v, e, "word");
	endtask
	// Writes land mid-word; the word already in flight is dropped
	task automatic mode(input logic [7:0] c, input int a12, al, at);
		logic [13:0] v;
		getw(0, v);
		{w12, lsb, twos} = {a12[0], al[0], at[0]};
		wr(`AFO_OFS_TEST_SEL, c);
		getw(0, v);
	endtask
	initial begin
		repeat (20) @(negedge mclk_i);
		rst_n_i = 1;
		foreach (ra[i]) rd(ra[i], 8'h00);
		foreach (ud[i]) wr(`AFO_OFS_USER1_LO + 8'(i), ud[i]);
		foreach (ud[i]) rd(`AFO_OFS_USER1_LO + 8'(i), ud[i]);
		for (int t = 0; t < 2; t++)
			foreach (cd[i]) begin
				mode({4'h0, cd[i]}, 0, 0, t[0]);
				expw(0, w1[i] ^ {i < 4 && t[0], 13'h0});
				expw(0, w2[i] ^ {i < 4 && t[0], 13'h0});
			end
		foreach (c12[i]) begin
			mode(c12[i], 1, 0, 0);
			getw(0, w);
			chk(i < 3 ? {2'b0, w[11:0]} : w, e12[i], "word12");
		end
		// Reversed short word must still start in the top bit
		mode(8'h0c, 1, 1, 0);
		getw(0, w);
		chk({2'b0, w[11:0]}, 14'h0cc5, "lsb12");
		mode(8'h0c, 0, 1, 0);
		expw(0, 14'h3985);
		mode(8'h06, 0, 0, 1);
		foreach (p9[i]) expw(0, p9[i]);
		mode(8'h05, 0, 0, 1);
		foreach (p23[i]) expw(0, p23[i]);
		for (int k = 0; k < 2; k++) begin
			mode(k ? 8'h25 : 8'h15, 0, 0, 1);
			mode(8'h05, 0, 0, 1);
			expw(0, p23[0]);
			expw(0, p23[1]);
		end
		mode(8'h00, 0, 0, 0);
		sel1_n = 1;
		repeat (4) @(negedge mclk_i);
		wr(`AFO_OFS_TEST_SEL, 8'h02);
		rd(`AFO_OFS_TEST_SEL, 8'h02);
		repeat (2) getw(1, w);
		expw(1, 14'h3fff);
		expw(0, 14'h1234);
		sel1_n = 0;
		repeat (4) @(negedge mclk_i);
		rd(`AFO_OFS_TEST_SEL, 8'h00);
		mode(8'h09, 0, 0, 0);
		for (int p = 0; p < 6; p++) begin
			ph = 3'(p);
			repeat (30) @(negedge mclk_i);
			w[0] = lanes[0];
			m = 0;
			while (lanes[0] === w[0] && m < 9) begin
				@(negedge mclk_i);
				m++;
			end
			if (m == 9) begin
				bad_count++;
				tally_and_finish();
			end
			w[0] = dclk[0];
			m = 0;
			while (dclk[0] === w[0] && m < 9) begin
				@(negedge mclk_i);
				m++;
			end
			if (m == 9) begin
				bad_count++;
				tally_and_finish();
			end
			if (p == 0)
				m0 = m;
			chk(14'((m - m0 + 6) % 6), 14'(p), "phase");
			// Step 3 puts the data clock edge half a bit after the data edge
			if (p == 3)
				chk(14'(m), 14'd3, "mid bit");
		end
		ph = 3'd3;
		// Both selects move together, as a strapped board would tie them
		{rst_n_i, sel1_n, sel2_n, fmt} = 4'b0111;
		repeat (20) @(negedge mclk_i);
		rst_n_i = 1;
		getw(0, w);
		expw(0, 14'h3234);
		wr(`AFO_OFS_TEST_SEL, 8'h02);
		rd(`AFO_OFS_TEST_SEL, 8'h00);
		{rst_n_i, pat} = 2'b01;
		repeat (20) @(negedge mclk_i);
		rst_n_i = 1;
		getw(0, w);
		expw(0, 14'h2000);
		expw(1, 14'h2000);
		chk({13'h0, sdo}, 14'h0000, "format pin out");
		tally_and_finish();
	end
endmodule
